// ===== input_ref_revalidation.sv
/*
 * Reference input requalification and loss-of-reference gating, with
 * a small register file, sticky status, mask and interrupt.
 * Assumes activity-monitor pulses and PLL lock status synchronous to clk.
 */
// Our own choices: the address-and-strobe port and the placing of the registers.
// Functional notes
// - Loss event loads counter from count setting
// - Each gapless valid period decrements by one
// - One missing period reloads and restarts count
// - Counter reaching zero clears the loss flag
// - Count in input periods, default 32
// - Undivided table: 2, 16, 32, 64 periods
// - Prescaled table: 8, 64, 128, 256 periods
// - Unmasked: lol or selected-input loss asserts
// - Masked: only true PLL lol asserts
// - Mask also keeps reference loss off lock
// - Per-input powerdown bit, default powered
`timescale 1ns/1ps
`default_nettype none
module input_ref_revalidation
  import requal_pkg::*;
#(
  parameter int N_IN = 2
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic [N_IN-1:0]   los_event,
  input  wire logic [N_IN-1:0]   period_valid,
  input  wire logic [N_IN-1:0]   period_missing,
  input  wire logic              pll_lol,
  output logic                   input0_powerdown,
  output logic                   input1_powerdown,
  output logic                   pll1_lol_sticky_n,
  output logic                   pll1_lol_live_n,
  output logic                   lock,
  output logic                   irq
);

  // Two inputs are wired to named pins and packed register fields
  if (N_IN != 2) begin : g_bad_inputs
    $error("N_IN must be 2");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]      count_sel;
    logic            prescale_en;
    logic [N_IN-1:0] powerdown;
    logic            loss_mask;
    logic            ref_sel;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] irq_mask;
    logic [31:0]     rdata;
    logic            live_n;
    logic            lock;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic [CNT_W-1:0] load_val;
  logic [N_IN-1:0]  los_flag;
  logic [N_IN-1:0]  req_done;
  logic [CNT_W-1:0] cnt_q [N_IN];
  logic             ref_fail;
  logic             lol_now;
  logic [ST_W-1:0]  events;
  logic [ST_W-1:0]  w1c;
  logic [31:0]      rd_val;

  // ****************************************************************
  // Count table
  // ****************************************************************
  // Prescale picks the second table instead of dividing the edges,
  // so both tables are exact period counts at the counter input.
  always_comb begin
    if (st.prescale_en) begin
      load_val = REQ_CNT_DIV4[st.count_sel];
    end else begin
      load_val = REQ_CNT_DIV1[st.count_sel];
    end
  end

  // ****************************************************************
  // Requalification channels
  // ****************************************************************
  // Every input gets its own counter and flag from one shared setting
  for (genvar i = 0; i < N_IN; i++) begin : g_chan
    requal_if #(.CW(CNT_W)) chan_bus ();

    assign chan_bus.los_event      = los_event[i];
    assign chan_bus.period_valid   = period_valid[i];
    assign chan_bus.period_missing = period_missing[i];
    assign chan_bus.powerdown      = st.powerdown[i];
    assign chan_bus.load_val       = load_val;
    assign los_flag[i]             = chan_bus.los;
    assign cnt_q[i]                = chan_bus.cnt;
    assign req_done[i]             = chan_bus.done;

    requal_channel #(
      .CW (CNT_W)
    ) u_chan (
      .clk (clk),
      .rst (rst),
      .ch  (chan_bus.chan)
    );
  end

  // ****************************************************************
  // Loss-of-reference gating
  // ****************************************************************
  // Only the selected input counts; the standby input may fail quietly
  assign ref_fail = los_flag[st.ref_sel] & ~st.loss_mask;
  assign lol_now  = pll_lol | ref_fail;

  // ****************************************************************
  // Events and register access
  // ****************************************************************
  // Loss events of a powered-down input are not reported
  always_comb begin
    events = '0;
    events[ST_LOS_LSB +: N_IN] = los_event & ~st.powerdown;
    events[ST_REQ_LSB +: N_IN] = req_done;
    events[ST_LOL]             = lol_now;
  end

  always_comb begin
    w1c = '0;
    if (reg_wr && reg_addr == OFS_STATUS) begin
      w1c = reg_wdata[ST_W-1:0];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_val = '0;
    unique case (reg_addr)
      OFS_CTRL: begin
        rd_val[CTRL_SEL_LSB +: 2]  = st.count_sel;
        rd_val[CTRL_PRESCALE]      = st.prescale_en;
        rd_val[CTRL_PD0]           = st.powerdown[0];
        rd_val[CTRL_PD1]           = st.powerdown[1];
        rd_val[CTRL_MASK_LOR]      = st.loss_mask;
        rd_val[CTRL_REF_SEL]       = st.ref_sel;
      end
      OFS_STATUS: begin
        rd_val[ST_W-1:0] = st.status;
      end
      OFS_MASK: begin
        rd_val[ST_W-1:0] = st.irq_mask;
      end
      OFS_LIVE: begin
        rd_val[LV_LOS_LSB +: N_IN]  = los_flag;
        rd_val[LV_LOL]              = ~st.live_n;
        rd_val[LV_CNT0_LSB +: CNT_W] = cnt_q[0];
        rd_val[LV_CNT1_LSB +: CNT_W] = cnt_q[1];
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      next_st.count_sel    = reg_wdata[CTRL_SEL_LSB +: 2];
      next_st.prescale_en  = reg_wdata[CTRL_PRESCALE];
      next_st.powerdown[0] = reg_wdata[CTRL_PD0];
      next_st.powerdown[1] = reg_wdata[CTRL_PD1];
      next_st.loss_mask    = reg_wdata[CTRL_MASK_LOR];
      next_st.ref_sel      = reg_wdata[CTRL_REF_SEL];
    end
    if (reg_wr && reg_addr == OFS_MASK) begin
      next_st.irq_mask = reg_wdata[ST_W-1:0];
    end
    // Set wins over clear so an event in the clearing cycle survives
    next_st.status = (st.status & ~w1c) | events;
    // Read data stands only in the cycle after the strobe
    next_st.rdata  = reg_rd ? rd_val : 32'h0000_0000;
    next_st.live_n = ~lol_now;
    next_st.lock   = ~lol_now;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st             <= '0;
      st.count_sel   <= SEL_RESET;
      st.prescale_en <= PRESCALE_RESET;
      st.powerdown   <= {N_IN{PD_RESET}};
      st.loss_mask   <= MASK_LOR_RESET;
      st.ref_sel     <= REF_SEL_RESET;
      st.live_n      <= 1'b1;
      st.lock        <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata         = st.rdata;
  assign input0_powerdown  = st.powerdown[0];
  assign input1_powerdown  = st.powerdown[1];
  assign pll1_lol_live_n   = st.live_n;
  assign pll1_lol_sticky_n = ~st.status[ST_LOL];
  assign lock              = st.lock;
  // Level interrupt, held while any unmasked sticky bit stands
  assign irq               = |(st.status & st.irq_mask);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ref_lost;
    !st.loss_mask && los_flag[st.ref_sel];
  endsequence

  // Bus-side steps shared by the register checks
  sequence s_ctrl_write;
    reg_wr && reg_addr == OFS_CTRL;
  endsequence
  sequence s_live_write;
    reg_wr && reg_addr == OFS_LIVE;
  endsequence
  sequence s_req0_clear;
    reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_REQ_LSB] && !req_done[0];
  endsequence
  sequence s_lol_clear;
    reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_LOL] && !lol_now;
  endsequence

  a_table_undivided: assert property (
    !st.prescale_en |-> load_val == (st.count_sel == 2'h0 ? 9'd2 :
      st.count_sel == 2'h1 ? 9'd16 : st.count_sel == 2'h2 ? 9'd32 : 9'd64))
    else $error("undivided count table wrong");
  a_table_prescaled: assert property (
    st.prescale_en |-> load_val == (st.count_sel == 2'h0 ? 9'd8 :
      st.count_sel == 2'h1 ? 9'd64 : st.count_sel == 2'h2 ? 9'd128 : 9'd256))
    else $error("prescaled count table wrong");
  a_shared_load: assert property (
    los_event[0] && !st.powerdown[0] |=> cnt_q[0] == $past(load_val))
    else $error("input count not taken from setting");
  a_ref_loss_flags: assert property (
    s_ref_lost |=> !pll1_lol_live_n && !pll1_lol_sticky_n)
    else $error("reference loss not flagged");
  a_masked_quiet: assert property (
    st.loss_mask && !pll_lol |=> pll1_lol_live_n)
    else $error("masked reference loss flagged");
  a_true_lol: assert property (
    pll_lol |=> !pll1_lol_live_n ##0 !pll1_lol_sticky_n)
    else $error("PLL loss of lock not flagged");
  a_lock_masked: assert property (
    st.loss_mask && !pll_lol |=> lock)
    else $error("masked reference loss dropped lock");
  a_powerdown_idle: assert property (
    st.powerdown[1] |=> !los_flag[1] && cnt_q[1] == '0)
    else $error("powered-down input still counting");
  a_sticky_hold: assert property (
    !pll1_lol_sticky_n && !(reg_wr && reg_addr == OFS_STATUS
      && reg_wdata[ST_LOL]) |=> !pll1_lol_sticky_n)
    else $error("sticky loss of lock dropped");

  // Read data stand one cycle only, so a late poll never sees stale words
  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data stood past its cycle");
  a_mask_readback: assert property (
    reg_rd && reg_addr == OFS_MASK |=> reg_rdata == 32'($past(st.irq_mask)))
    else $error("mask register read back wrong");
  a_ctrl_pins: assert property (
    s_ctrl_write |=> {input1_powerdown, input0_powerdown}
      == $past(reg_wdata[CTRL_PD1:CTRL_PD0]))
    else $error("powerdown pins do not follow control write");
  // The live register is read only; a stray write must not reach control
  a_live_readonly: assert property (
    s_live_write |=> $stable(st.count_sel) && $stable(st.irq_mask) && $stable(st.powerdown))
    else $error("live register took a write");

  // Sticky status: an event in the clearing cycle must survive the clear
  a_set_wins: assert property (
    req_done[0] |=> st.status[ST_REQ_LSB])
    else $error("requalified status lost");
  a_clear_req: assert property (
    s_req0_clear |=> !st.status[ST_REQ_LSB])
    else $error("requalified status not cleared");
  a_lol_clear: assert property (
    s_lol_clear |=> pll1_lol_sticky_n)
    else $error("sticky loss of lock not cleared");
  a_loss_status: assert property (
    los_event[1] && !st.powerdown[1] |=> los_flag[1] && st.status[ST_LOS_LSB + 1])
    else $error("loss event not recorded");

  // Lock pin drops on an unmasked loss of the selected reference
  a_lock_ref_loss: assert property (
    s_ref_lost |=> !lock)
    else $error("unmasked reference loss kept lock");

endmodule
`default_nettype wire

// ===== ref_source_model.sv
/*
 * Model of one reference clock source as seen through the activity
 * monitor: loss events, valid periods and missing periods as pulses.
 * Assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
module ref_source_model (
  input  wire logic clk,
  output logic      loss,
  output logic      valid,
  output logic      missing
);
  // ****************************************************************
  // Pulse generation
  // ****************************************************************
  // Quiet source at start: no edges reported yet
  initial begin
    loss    = 1'b0;
    valid   = 1'b0;
    missing = 1'b0;
  end

  // Input stops toggling: one loss pulse
  task automatic lose();
    @(posedge clk);
    loss <= 1'b1;
    @(posedge clk);
    loss <= 1'b0;
    #1;
  endtask

  // Edges absent for exactly one input period
  task automatic miss();
    @(posedge clk);
    missing <= 1'b1;
    @(posedge clk);
    missing <= 1'b0;
    #1;
  endtask

  // A run of n good periods; slow spaces them out like a slower input
  task automatic periods(input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      valid <= 1'b1;
      if (slow) begin
        @(posedge clk);
        valid <= 1'b0;
      end
    end
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== requal_channel.sv
/*
 * One input's requalification counter and loss-of-signal flag.
 * Assumes one-cycle period pulses from the activity monitor, on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module requal_channel
  import requal_pkg::*;
#(
  parameter int CW = 9
)(
  input  wire logic clk,
  input  wire logic rst,
  requal_if.chan    ch
);

  // The longest prescaled count needs nine bits
  if (CW < 9) begin : g_bad_width
    $error("CW too small for 256 periods");
  end

  typedef struct packed {
    logic          los;
    logic [CW-1:0] cnt;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;

  // ****************************************************************
  // Counter and flag
  // ****************************************************************
  // A powered-down input is parked clear so it never counts stale edges
  always_comb begin
    next_st = st;
    if (ch.powerdown) begin
      next_st.los = 1'b0;
      next_st.cnt = '0;
    end else if (ch.los_event) begin
      next_st.los = 1'b1;
      next_st.cnt = ch.load_val;
    end else if (st.los) begin
      if (ch.period_missing) begin
        next_st.cnt = ch.load_val;
      end else if (ch.period_valid) begin
        if (st.cnt == CW'(1)) begin
          next_st.cnt = '0;
          next_st.los = 1'b0;
        end else begin
          next_st.cnt = st.cnt - CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ch.los  = st.los;
  assign ch.cnt  = st.cnt;
  // Pulse in the cycle the counter reaches zero
  assign ch.done = st.los & ~next_st.los & ~ch.powerdown & ~ch.los_event;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_period;
    st.los && st.cnt == CW'(1) && ch.period_valid && !ch.period_missing
      && !ch.los_event && !ch.powerdown;
  endsequence
  sequence s_requalified;
    !st.los && st.cnt == '0;
  endsequence

  a_load_on_loss: assert property (
    ch.los_event && !ch.powerdown |=> st.los && st.cnt == $past(ch.load_val))
    else $error("counter not loaded on loss event");
  a_count_down_one: assert property (
    st.los && st.cnt > CW'(1) && ch.period_valid && !ch.period_missing
      && !ch.los_event && !ch.powerdown |=> st.cnt == $past(st.cnt) - CW'(1))
    else $error("counter did not drop by one");
  a_reload_missing: assert property (
    st.los && ch.period_missing && !ch.los_event && !ch.powerdown
      |=> st.los && st.cnt == $past(ch.load_val))
    else $error("counter not reloaded on missing period");
  a_requal_clear: assert property (
    s_last_period |-> ch.done ##1 s_requalified)
    else $error("input not requalified at zero");
  a_flag_held: assert property (
    $fell(st.los) |-> $past(st.cnt) == CW'(1) || $past(ch.powerdown))
    else $error("loss flag cleared early");

endmodule
`default_nettype wire

// ===== requal_if.sv
/*
 * Signals between the control logic and one requalification channel.
 * Assumes all signals are synchronous to the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface requal_if #(
  parameter int CW = 9
);
  logic          los_event;
  logic          period_valid;
  logic          period_missing;
  logic          powerdown;
  logic [CW-1:0] load_val;
  logic          los;
  logic [CW-1:0] cnt;
  logic          done;

  modport chan (input los_event, period_valid, period_missing, powerdown,
                load_val, output los, cnt, done);
  modport ctrl (output los_event, period_valid, period_missing, powerdown,
                load_val, input los, cnt, done);
endinterface
`default_nettype wire

// ===== requal_pkg.sv
/*
 * Constants for the reference requalification block: register offsets,
 * field positions, reset values and the requalification count tables.
 * Assumes a 32-bit register port with word-aligned byte offsets.
 */
package requal_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MASK    = 8'h08;
  localparam logic [7:0] OFS_LIVE    = 8'h0c;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_SEL_LSB   = 0;  // requal_count_sel, two bits
  localparam int CTRL_PRESCALE  = 2;  // requal_prescale_en
  localparam int CTRL_PD0       = 3;  // input0_powerdown
  localparam int CTRL_PD1       = 4;  // input1_powerdown
  localparam int CTRL_MASK_LOR  = 5;  // ref_loss_mask
  localparam int CTRL_REF_SEL   = 6;  // selected reference input
  localparam int CTRL_W         = 7;

  localparam logic [1:0] SEL_RESET      = 2'h2;  // 32 periods
  localparam logic       PRESCALE_RESET = 1'h0;  // divide-by-one
  localparam logic       PD_RESET       = 1'h0;  // powered and enabled
  localparam logic       MASK_LOR_RESET = 1'h0;  // not blocked
  localparam logic       REF_SEL_RESET  = 1'h0;

  // ****************************************************************
  // Status / mask fields (sticky, write one to clear)
  // ****************************************************************
  localparam int ST_LOS_LSB   = 0;  // loss event, one bit per input
  localparam int ST_REQ_LSB   = 2;  // requalified, one bit per input
  localparam int ST_LOL       = 4;  // loss-of-lock seen
  localparam int ST_W         = 5;

  // Live register fields
  localparam int LV_LOS_LSB   = 0;
  localparam int LV_LOL       = 2;
  localparam int LV_CNT0_LSB  = 3;
  localparam int LV_CNT1_LSB  = 12;

  // ****************************************************************
  // Requalification count tables, indexed by requal_count_sel
  // ****************************************************************
  localparam int CNT_W = 9;
  localparam logic [3:0][CNT_W-1:0] REQ_CNT_DIV1 =
    {9'h040, 9'h020, 9'h010, 9'h002};
  localparam logic [3:0][CNT_W-1:0] REQ_CNT_DIV4 =
    {9'h100, 9'h080, 9'h040, 9'h008};

endpackage

// ===== testbench.sv
/*
 * Self-checking bench for the reference requalification block.
 * Assumes one ref_source_model per input and the plain register port.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import requal_pkg::*;
;
  // ****************************************************************
  // Signals, design and sources
  // ****************************************************************
  logic              clk, rst, reg_wr, reg_rd, pll_lol;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, d;
  wire logic [1:0]   los_event, period_valid, period_missing;
  logic              pd0, pd1, st_n, lv_n, lock, irq;
  int                error_cnt, check_count;
  localparam int     T1[4] = '{2, 16, 32, 64};
  localparam int     T4[4] = '{8, 64, 128, 256};

  input_ref_revalidation #(.N_IN(2)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .los_event(los_event), .period_valid(period_valid),
    .period_missing(period_missing), .pll_lol(pll_lol),
    .input0_powerdown(pd0), .input1_powerdown(pd1), .pll1_lol_sticky_n(st_n),
    .pll1_lol_live_n(lv_n), .lock(lock), .irq(irq));
  ref_source_model src0 (.clk(clk), .loss(los_event[0]), .valid(period_valid[0]),
                         .missing(period_missing[0]));
  ref_source_model src1 (.clk(clk), .loss(los_event[1]), .valid(period_valid[1]),
                         .missing(period_missing[1]));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // ****************************************************************
  // Bus, compare and closing tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(OFS_CTRL, d);
    chk("ctrl_reset", d, 32'h0000_0002);
    wr(8'h10, 32'hffff_ffff);
    wr(OFS_LIVE, 32'hffff_ffff);
    rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    rd(OFS_CTRL, d);
    chk("ctrl_kept", d, 32'h0000_0002);
    rd(OFS_MASK, d);
    chk("mask_reset", d, 32'h0);
    chk("pd_reset", 32'({pd1, pd0}), 32'h0);
    chk("lock_reset", 32'({lock, lv_n, st_n, irq}), 32'he);
    $display("done reset");
  endtask

  // Every code in both tables, slow and prompt sources alternating
  task automatic t_table();
    int n;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        n = (p == 1) ? T4[s] : T1[s];
        wr(OFS_CTRL, 32'(s) | (32'(p) << CTRL_PRESCALE));
        src0.lose();
        rd(OFS_LIVE, d);
        chk("count_load", 32'(d[LV_CNT0_LSB +: CNT_W]), 32'(n));
        src0.periods(n - 1, s % 2 == 1);
        rd(OFS_LIVE, d);
        chk("count_last", 32'(d[LV_CNT0_LSB +: CNT_W]), 32'h1);
        chk("flag_held", 32'(d[LV_LOS_LSB]), 32'h1);
        src0.periods(1, 1'b0);
        rd(OFS_LIVE, d);
        chk("flag_clear", 32'(d[LV_LOS_LSB]), 32'h0);
        rd(OFS_STATUS, d);
        chk("requal_bit", 32'(d[ST_REQ_LSB]), 32'h1);
        wr(OFS_STATUS, 32'h1f);
      end
    end
    $display("done table");
  endtask

  // A gap one short of the end must restart the full count
  task automatic t_missing();
    wr(OFS_CTRL, 32'h1);
    src0.lose();
    src0.periods(15, 1'b0);
    src0.miss();
    rd(OFS_LIVE, d);
    chk("count_reload", 32'(d[LV_CNT0_LSB +: CNT_W]), 32'd16);
    chk("flag_after_gap", 32'(d[LV_LOS_LSB]), 32'h1);
    src0.periods(16, 1'b0);
    rd(OFS_LIVE, d);
    chk("flag_restart", 32'(d[LV_LOS_LSB]), 32'h0);
    $display("done missing");
  endtask

  task automatic t_indep();
    wr(OFS_CTRL, 32'h0);
    src0.lose();
    src1.lose();
    src1.periods(2, 1'b0);
    rd(OFS_LIVE, d);
    chk("flags_indep", 32'(d[1:0]), 32'h1);
    chk("cnt0_untouched", 32'(d[LV_CNT0_LSB +: CNT_W]), 32'h2);
    src0.periods(2, 1'b1);
    wr(OFS_STATUS, 32'h1f);
    $display("done independent");
  endtask

  task automatic t_lock();
    src1.lose();
    idle(3);
    chk("other_input", 32'({lv_n, lock}), 32'h3);
    src0.lose();
    idle(2);
    chk("ref_loss", 32'({lv_n, lock, st_n}), 32'h0);
    wr(OFS_CTRL, 32'h2 | (32'h1 << CTRL_MASK_LOR));
    idle(3);
    chk("ref_blocked", 32'({lv_n, lock}), 32'h3);
    @(posedge clk);
    pll_lol <= 1'b1;
    idle(2);
    chk("pll_loss", 32'({lv_n, lock}), 32'h0);
    @(posedge clk);
    pll_lol <= 1'b0;
    idle(3);
    chk("sticky_held", 32'({lv_n, st_n}), 32'h2);
    wr(OFS_STATUS, 32'h1 << ST_LOL);
    idle(2);
    chk("sticky_clear", 32'(st_n), 32'h1);
    src0.periods(32, 1'b0);
    src1.periods(32, 1'b0);
    wr(OFS_STATUS, 32'h1f);
    $display("done lock");
  endtask

  task automatic t_irq();
    src1.lose();
    rd(OFS_STATUS, d);
    chk("status_loss", d, 32'h2);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_MASK, 32'h2);
    idle(2);
    chk("irq_set", 32'(irq), 32'h1);
    wr(OFS_STATUS, 32'h2);
    idle(2);
    chk("irq_clear", 32'(irq), 32'h0);
    src1.periods(32, 1'b0);
    $display("done irq");
  endtask

  task automatic t_powerdown();
    wr(OFS_CTRL, 32'h2 | (32'h1 << CTRL_PD0));
    idle(2);
    chk("pd_outputs", 32'({pd1, pd0}), 32'h1);
    src0.lose();
    rd(OFS_LIVE, d);
    chk("pd_ignores_loss", 32'(d[1:0]), 32'h0);
    wr(OFS_CTRL, 32'h2 | (32'h3 << CTRL_PD0));
    idle(2);
    chk("pd_both", 32'({pd1, pd0}), 32'h3);
    $display("done powerdown");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pll_lol = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    idle(2);
    t_reset();
    t_table();
    t_missing();
    t_indep();
    t_lock();
    t_irq();
    t_powerdown();
    tally_and_finish();
  end

  // Whole run needs about 1300 cycles; allow generous margin
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
